// >>> src/bat_regs.svh
`ifndef BAT_REGS_SVH
`define BAT_REGS_SVH

// ****************************************************************
// clock selection codes
// ****************************************************************
`define BAT_CLK_CORE        2'h0
`define BAT_CLK_EXT_256     2'h1
`define BAT_CLK_EXT_384     2'h2
`define BAT_CLK_EXT_512     2'h3

// ****************************************************************
// time slot dividers (clocks per time slot, 128 slots per frame)
// ****************************************************************
`define BAT_DIV_CORE        4'h8
`define BAT_DIV_256         4'h2
`define BAT_DIV_384         4'h3
`define BAT_DIV_512         4'h4
`define BAT_DIV_ONE         4'h1

// ****************************************************************
// subframe layout
// ****************************************************************
`define BAT_SLOT_FIRST      6'h00
`define BAT_SLOT_PRE_LAST   6'h07
`define BAT_SLOT_PARITY     6'h3e
`define BAT_SLOT_LAST       6'h3f
`define BAT_PRE_TOP         3'h7
`define BAT_SR_WIDTH        27
`define BAT_AUDIO_WIDTH     24

// ****************************************************************
// preambles, written for a line that sat low before them
// ****************************************************************
`define BAT_PRE_X           8'he2
`define BAT_PRE_Y           8'he4
`define BAT_PRE_Z           8'he8

// ****************************************************************
// block length and interrupt vectors
// ****************************************************************
`define BAT_FRAME_LAST      8'hbf
`define BAT_FRAME_FIRST     8'h00
`define BAT_VEC_UNDERRUN    8'h28
`define BAT_VEC_BLOCK       8'h2a
`define BAT_VEC_EMPTY       8'h2e
`define BAT_VEC_NONE        8'h00

`endif

// >>> src/bat_pkg.sv
package bat_pkg;

   // ****************************************************************
   // non-audio bits of one channel, sent as subframe bits 28..30
   // ****************************************************************
   typedef struct packed {
      logic status;
      logic user;
      logic validity;
   } bat_na_s;

   // stored non-audio word: channel b above channel a
   typedef struct packed {
      bat_na_s chan_b;
      bat_na_s chan_a;
   } bat_nonaudio_s;

   // interrupt enables
   typedef struct packed {
      logic block_irq_enable;
      logic underrun_irq_enable;
      logic empty_irq_enable;
   } bat_irq_en_s;

   // status flags
   typedef struct packed {
      logic block_done_flag;
      logic underrun_flag;
      logic audio_empty_flag;
   } bat_status_s;

   // subframe being sent
   typedef enum logic {
      BAT_CH_A,
      BAT_CH_B
   } bat_chan_e;

   // preamble kinds
   typedef enum logic [1:0] {
      BAT_PRE_KIND_X,
      BAT_PRE_KIND_Y,
      BAT_PRE_KIND_Z
   } bat_pre_e;

endpackage

// >>> src/bat_transmitter.sv
// Summary of operation
// RULE1: sends one frame at a time: channel a subframe, then channel b subframe.
// RULE2: double-buffered path lets next frame load while current one is sent.
// RULE3: core clock source makes the block master, external clock makes it slave.
// RULE4: external source must give 256, 384 or 512 times the sample rate.
// RULE5: each pin is gpio or dedicated; block held in reset unless one is dedicated.
// RULE6: output pin sends biphase-mark data; gpio only while block not operating.
// RULE7: clock pin is gpio when block disabled or running from core clock.
// RULE8: channel a word goes to buffer a; channel b word to buffer b once empty.
// RULE9: buffer a loads shifter after last bit; then buffer b loads for channel b.
// RULE10: at frame start, non-audio bits go to shifter (a) and buffer (b).
// RULE11: empty flag set when holding reg and buffer a empty; interrupt if enabled.
// RULE12: on empty interrupt host writes non-audio bits, then both audio words.
// RULE13: frame opens with 8-slot preamble: z at block start, x otherwise.
// RULE14: then 24 audio and 3 non-audio bits go out in 54 time slots.
// RULE15: even parity over those 27 bits sent in the last two slots.
// RULE16: channel b starts with y preamble right after a parity; shifter loads then.
// RULE17: vectors: underrun 28 hex, block done 2a hex, empty 2e hex.
// RULE18: priority: underrun highest, block done next, empty lowest.
// RULE19: clock select 00 core at 1024 fs; 01, 10, 11 external at 256, 384, 512 fs.
// RULE20: validity, user, status bits sent as subframe bits 28, 29, 30.
// RULE21: start-block bit forces next frame to open with z; cleared when block starts.
// RULE22: enables gate underrun on its flag, block on block and empty flags.
// RULE23: missing data at subframe start sets underrun flag; old data resent.
// RULE24: block flag set after 192 frames counted from the last z preamble.
`timescale 1ns/1ps
`default_nettype none
`include "bat_regs.svh"

module bat_transmitter (
   // clock and reset
   input  wire logic                   core_clk_in,
   input  wire logic                   srst_in,
   // pin function selects (1 = dedicated to the transmitter)
   input  wire logic                   out_pin_dedicated_in,
   input  wire logic                   clk_pin_dedicated_in,
   // configuration
   input  wire logic [1:0]             clock_source_select_in,
   input  wire bat_pkg::bat_irq_en_s   irq_enable_in,
   input  wire logic                   force_block_start_set_in,
   // audio and non-audio writes
   input  wire logic                   audio_wr_in,
   input  wire logic [23:0]            audio_data_in,
   input  wire logic                   nonaudio_wr_in,
   input  wire bat_pkg::bat_nonaudio_s nonaudio_bits_in,
   // flag clears from software
   input  wire logic                   underrun_clr_in,
   input  wire logic                   block_clr_in,
   // status and interrupt request
   output logic                        force_block_start_out,
   output bat_pkg::bat_status_s        status_out,
   output logic                        irq_req_out,
   output logic [7:0]                  irq_vector_out,
   // serial output pin and its gpio alias
   input  wire logic                   output_pin_gpio_alias_in,
   input  wire logic                   output_pin_gpio_oe_in,
   output logic                        serial_audio_out_pin_out,
   output logic                        serial_audio_out_pin_oe_out,
   // external clock pin and its gpio alias
   input  wire logic                   external_audio_clock_pin_in,
   output logic                        clock_pin_gpio_alias_out,
   output logic                        operating_out
);
   import bat_pkg::*;

   // ****************************************************************
   // functions
   // ****************************************************************
   // preamble pattern, inverted when the line was left high
   function automatic logic [7:0] pre_pattern(input bat_pre_e kind, input logic level);
      logic [7:0] pat;
      pat = `BAT_PRE_X;
      case (kind)
         BAT_PRE_KIND_Y: pat = `BAT_PRE_Y;
         BAT_PRE_KIND_Z: pat = `BAT_PRE_Z;
         default:        pat = `BAT_PRE_X;
      endcase
      return level ? ~pat : pat;
   endfunction

   // clocks per time slot for each source
   function automatic logic [3:0] slot_div(input logic [1:0] sel);
      logic [3:0] d;
      d = `BAT_DIV_CORE;
      case (sel)
         `BAT_CLK_EXT_256: d = `BAT_DIV_256;
         `BAT_CLK_EXT_384: d = `BAT_DIV_384;
         `BAT_CLK_EXT_512: d = `BAT_DIV_512;
         default:          d = `BAT_DIV_CORE;
      endcase
      return d;
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic                       operating;
   logic                       blk_rst;
   logic                       ext_clk_sel;
   logic                       ext_prev_r;
   logic                       src_edge;
   logic [3:0]                 div_cnt_r;
   logic                       tick;
   bat_chan_e                  chan_r;
   logic [5:0]                 slot_r;
   logic                       sub_start;
   logic                       frame_end;
   logic [`BAT_SR_WIDTH-1:0]   shift_r;
   logic                       parity_r;
   logic                       line_r;
   logic [7:0]                 pre_r;
   logic [7:0]                 pre_now;
   logic                       z_start;
   logic                       bit_val;
   logic [23:0]                hold_r;
   logic                       hold_v_r;
   logic                       hold_b_r;
   logic                       wr_b_r;
   logic [23:0]                buf_a_r;
   logic                       buf_a_v_r;
   logic [23:0]                buf_b_r;
   logic                       buf_b_v_r;
   bat_nonaudio_s              na_r;
   bat_na_s                    na_buf_r;
   logic [7:0]                 frame_cnt_r;
   logic                       force_r;
   logic                       empty_r;
   logic                       underrun_r;
   logic                       block_r;
   logic                       ur_event;
   logic                       blk_event;
   logic                       pin_r;

   // ****************************************************************
   // reset and pin ownership
   // ****************************************************************
   // held in reset while both pins are gpio
   assign operating   = out_pin_dedicated_in | clk_pin_dedicated_in;                    // RULE5
   assign blk_rst     = srst_in | ~operating;                                          // RULE5
   assign ext_clk_sel = clock_source_select_in != `BAT_CLK_CORE;                       // RULE3
   assign operating_out = operating;
   // clock pin free for gpio when disabled or on the core clock
   assign clock_pin_gpio_alias_out = ~operating | ~ext_clk_sel;                        // RULE7

   // output pin: serial data while operating, gpio only otherwise
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pin_r <= 1'b0;
      end else if (operating) begin
         pin_r <= line_r;                                                              // RULE6
      end else begin
         pin_r <= output_pin_gpio_alias_in;
      end
   end
   assign serial_audio_out_pin_out    = pin_r;
   assign serial_audio_out_pin_oe_out = operating | output_pin_gpio_oe_in;             // RULE6

   // ****************************************************************
   // time slot enable
   // ****************************************************************
   // external clock is taken as synchronous; its rising edges are counted
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= external_audio_clock_pin_in;
      end
   end
   // core path counts every clock (master), external path counts pin edges (slave)
   assign src_edge = ext_clk_sel ? (external_audio_clock_pin_in & ~ext_prev_r) : 1'b1; // RULE3
   assign tick     = src_edge && (div_cnt_r == slot_div(clock_source_select_in) - `BAT_DIV_ONE);

   // the external source must run at 256, 384 or 512 fs for these divisors
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         div_cnt_r <= 4'h0;
      end else if (tick) begin
         div_cnt_r <= 4'h0;                                                            // RULE19
      end else if (src_edge) begin
         div_cnt_r <= div_cnt_r + `BAT_DIV_ONE;                                        // RULE4
      end
   end

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   assign sub_start = tick && (slot_r == `BAT_SLOT_FIRST);
   assign frame_end = tick && (slot_r == `BAT_SLOT_LAST) && (chan_r == BAT_CH_B);
   assign z_start   = (frame_cnt_r == `BAT_FRAME_FIRST) | force_r;                    // RULE13

   // slot counter and channel: a subframe then b subframe, 64 slots each
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         slot_r <= `BAT_SLOT_FIRST;
         chan_r <= BAT_CH_A;
      end else if (tick) begin
         slot_r <= slot_r + 6'h01;
         if (slot_r == `BAT_SLOT_LAST) begin
            case (chan_r)
               BAT_CH_A: chan_r <= BAT_CH_B;                                           // RULE1
               BAT_CH_B: chan_r <= BAT_CH_A;                                           // RULE1
               default:  chan_r <= BAT_CH_A;
            endcase
         end
      end
   end

   // frame counter within a block; restarted by a forced block start
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         frame_cnt_r <= `BAT_FRAME_FIRST;
      end else if (sub_start && chan_r == BAT_CH_A && force_r) begin
         frame_cnt_r <= `BAT_FRAME_FIRST;                                              // RULE21
      end else if (frame_end) begin
         frame_cnt_r <= (frame_cnt_r == `BAT_FRAME_LAST) ? `BAT_FRAME_FIRST
                                                        : frame_cnt_r + 8'h01;         // RULE24
      end
   end
   assign blk_event = frame_end && (frame_cnt_r == `BAT_FRAME_LAST);                   // RULE24

   // start-block request: set wins over the hardware clear
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         force_r <= 1'b0;
      end else if (force_block_start_set_in) begin
         force_r <= 1'b1;
      end else if (sub_start && chan_r == BAT_CH_A) begin
         force_r <= 1'b0;                                                              // RULE21
      end
   end
   assign force_block_start_out = force_r;

   // ****************************************************************
   // holding register and channel buffers
   // ****************************************************************
   // writes alternate channel a, channel b
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         hold_r   <= 24'h000000;
         hold_v_r <= 1'b0;
         hold_b_r <= 1'b0;
         wr_b_r   <= 1'b0;
      end else if (audio_wr_in) begin
         hold_r   <= audio_data_in;
         hold_v_r <= 1'b1;
         hold_b_r <= wr_b_r;
         wr_b_r   <= ~wr_b_r;
      end else if (hold_v_r && !hold_b_r && !buf_a_v_r) begin
         hold_v_r <= 1'b0;                                                             // RULE8
      end else if (hold_v_r && hold_b_r && !buf_b_v_r) begin
         hold_v_r <= 1'b0;                                                             // RULE8
      end
   end

   // buffers move into the shifter at each subframe start; the data stays
   // behind so an underrun simply resends the previous word
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         buf_a_r   <= 24'h000000;
         buf_a_v_r <= 1'b0;
         buf_b_r   <= 24'h000000;
         buf_b_v_r <= 1'b0;
      end else begin
         // a load into an empty buffer wins, since the holding register lets go of it
         if (hold_v_r && !hold_b_r && !buf_a_v_r) begin
            buf_a_r   <= hold_r;                                                       // RULE8
            buf_a_v_r <= 1'b1;                                                         // RULE2
         end else if (sub_start && chan_r == BAT_CH_A) begin
            buf_a_v_r <= 1'b0;                                                         // RULE9
         end
         if (hold_v_r && hold_b_r && !buf_b_v_r) begin
            buf_b_r   <= hold_r;                                                       // RULE8
            buf_b_v_r <= 1'b1;                                                         // RULE2
         end else if (sub_start && chan_r == BAT_CH_B) begin
            buf_b_v_r <= 1'b0;                                                         // RULE9
         end
      end
   end

   // stored non-audio bits; the host writes them before the audio words
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         na_r <= '0;
      end else if (nonaudio_wr_in) begin
         na_r <= nonaudio_bits_in;                                                     // RULE12
      end
   end

   // channel b non-audio bits are uploaded at frame start
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         na_buf_r <= '0;
      end else if (sub_start && chan_r == BAT_CH_A) begin
         na_buf_r <= na_r.chan_b;                                                      // RULE10
      end
   end

   // ****************************************************************
   // shifter, parity and biphase-mark encoder
   // ****************************************************************
   assign pre_now = pre_pattern((chan_r == BAT_CH_B) ? BAT_PRE_KIND_Y
                                : (z_start ? BAT_PRE_KIND_Z : BAT_PRE_KIND_X), line_r);
   assign bit_val = (slot_r >= `BAT_SLOT_PARITY) ? parity_r : shift_r[0];

   // shifter: shifts toward bit 0, one data bit per two slots
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         shift_r  <= '0;
         parity_r <= 1'b0;
      end else if (sub_start) begin
         parity_r <= 1'b0;
         if (chan_r == BAT_CH_A) begin
            shift_r <= {na_r.chan_a, buf_a_r};                                         // RULE20
         end else begin
            shift_r <= {na_buf_r, buf_b_r};                                            // RULE16
         end
      end else if (tick && slot_r > `BAT_SLOT_PRE_LAST && slot_r[0]
                   && slot_r < `BAT_SLOT_PARITY) begin
         shift_r  <= {1'b0, shift_r[`BAT_SR_WIDTH-1:1]};                               // RULE14
         parity_r <= parity_r ^ shift_r[0];                                            // RULE15
      end
   end

   // line level: preamble slots, then one transition per bit plus mid-bit for ones
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         line_r <= 1'b0;
         pre_r  <= 8'h00;
      end else if (sub_start) begin
         pre_r  <= pre_now;
         line_r <= pre_now[`BAT_PRE_TOP];                                              // RULE13
      end else if (tick && slot_r <= `BAT_SLOT_PRE_LAST) begin
         line_r <= pre_r[`BAT_PRE_TOP - slot_r[2:0]];                                  // RULE16
      end else if (tick && !slot_r[0]) begin
         line_r <= ~line_r;                                                            // RULE14
      end else if (tick) begin
         line_r <= line_r ^ bit_val;                                                   // RULE15
      end
   end

   // ****************************************************************
   // status flags and interrupt request
   // ****************************************************************
   // missing buffer at a subframe start means the old word is resent
   assign ur_event = sub_start && ((chan_r == BAT_CH_A) ? !buf_a_v_r : !buf_b_v_r);    // RULE23

   // events win over software clears
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         underrun_r <= 1'b0;
      end else if (ur_event) begin
         underrun_r <= 1'b1;                                                           // RULE23
      end else if (underrun_clr_in) begin
         underrun_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         block_r <= 1'b0;
      end else if (blk_event) begin
         block_r <= 1'b1;                                                              // RULE24
      end else if (block_clr_in) begin
         block_r <= 1'b0;
      end
   end

   // empty while neither holding register nor buffer a has data
   always_ff @(posedge core_clk_in) begin
      if (blk_rst) begin
         empty_r <= 1'b0;
      end else begin
         empty_r <= !hold_v_r && !buf_a_v_r;                                           // RULE11
      end
   end

   assign status_out.audio_empty_flag = empty_r;
   assign status_out.underrun_flag    = underrun_r;
   assign status_out.block_done_flag  = block_r;

   // fixed vectors in fixed priority order
   always_comb begin
      irq_req_out    = 1'b1;
      irq_vector_out = `BAT_VEC_NONE;
      if (underrun_r && irq_enable_in.underrun_irq_enable) begin
         irq_vector_out = `BAT_VEC_UNDERRUN;                                           // RULE17
      end else if (block_r && empty_r && irq_enable_in.block_irq_enable) begin
         irq_vector_out = `BAT_VEC_BLOCK;                                              // RULE22
      end else if (empty_r && irq_enable_in.empty_irq_enable) begin
         irq_vector_out = `BAT_VEC_EMPTY;                                              // RULE18
      end else begin
         irq_req_out = 1'b0;
      end
   end

endmodule // bat_transmitter
`default_nettype wire

// >>> test/bat_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bat_chk (
   input wire logic                 core_clk_in,
   input wire logic                 srst_in,
   input wire logic                 out_pin_dedicated_in,
   input wire logic                 clk_pin_dedicated_in,
   input wire logic [1:0]           clock_source_select_in,
   input wire bat_pkg::bat_irq_en_s irq_enable_in,
   input wire bat_pkg::bat_status_s status_out,
   input wire logic                 irq_req_out,
   input wire logic [7:0]           irq_vector_out,
   input wire logic                 clock_pin_gpio_alias_out,
   input wire logic                 operating_out
);
   import bat_pkg::*;
   logic u, b, e;
   // live sources, listed in priority order
   assign u = irq_enable_in.underrun_irq_enable && status_out.underrun_flag;
   assign b = irq_enable_in.block_irq_enable && status_out.block_done_flag
              && status_out.audio_empty_flag;
   assign e = irq_enable_in.empty_irq_enable && status_out.audio_empty_flag;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   a_vec_under: assert property (u |-> irq_req_out && irq_vector_out == 8'h28)
      else $error("underrun vector");
   a_vec_block: assert property (!u && b |-> irq_req_out && irq_vector_out == 8'h2a)
      else $error("block vector");
   a_vec_empty: assert property (!u && !b && e |-> irq_req_out && irq_vector_out == 8'h2e)
      else $error("empty vector");
   a_irq_quiet: assert property (!u && !b && !e |-> !irq_req_out && irq_vector_out == 8'h00)
      else $error("stray request");
   a_pins_run: assert property (operating_out == (out_pin_dedicated_in || clk_pin_dedicated_in))
      else $error("operating mismatch");
   a_clk_free: assert property (clock_pin_gpio_alias_out ==
      (!operating_out || clock_source_select_in == 2'h0)) else $error("clock pin use");
   a_idle_clear: assert property (!operating_out |=> status_out == '0)
      else $error("flags kept while idle");
   a_idle_quiet: assert property (!operating_out ##1 !operating_out |-> !irq_req_out)
      else $error("request while idle");
endmodule // bat_chk
bind bat_transmitter bat_chk i_chk (.core_clk_in, .srst_in, .out_pin_dedicated_in,
   .clk_pin_dedicated_in, .clock_source_select_in, .irq_enable_in, .status_out,
   .irq_req_out, .irq_vector_out, .clock_pin_gpio_alias_out, .operating_out);
`default_nettype wire

// >>> test/bat_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module bat_rx_model (
   input  wire logic   clk_in,
   input  wire logic   arm_in,
   input  wire logic   line_in,
   output logic        valid_out,
   output logic [7:0]  pre_out,
   output logic [27:0] bits_out
);
   logic        prev_r, run_r;
   logic [2:0]  tick_r;
   logic [5:0]  slot_r;
   logic [63:0] sh_r;
   // lock on first rising edge after arming, so a gpio level falling away is no frame;
   // then sample mid-slot, 8 clocks a slot
   always_ff @(posedge clk_in) begin
      prev_r    <= line_in;
      run_r     <= arm_in && (run_r || (line_in && !prev_r));
      tick_r    <= run_r ? tick_r + 3'h1 : 3'h1;
      slot_r    <= run_r ? slot_r + {5'h00, tick_r == 3'h4} : 6'h00;
      valid_out <= run_r && tick_r == 3'h4 && slot_r == 6'h3f;
      if (tick_r == 3'h4) sh_r <= {sh_r[62:0], line_in};
   end
   // preamble folded to a low start; a bit is the mid-cell flip
   always_comb begin
      pre_out = sh_r[63] ? sh_r[63:56] : ~sh_r[63:56];
      for (int k = 0; k < 28; k++) bits_out[k] = sh_r[55 - 2 * k] ^ sh_r[54 - 2 * k];
   end
endmodule // bat_rx_model
`default_nettype wire

// >>> test/biphase_audio_transmitter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bat_regs.svh"
module biphase_audio_transmitter_bench;
   import bat_pkg::*;
   logic          clk = 1'b0, oe;
   logic          srst, o_ded, c_ded, sb, a_wr, n_wr, u_clr, g_val, sb_q, irq, pin, c_free, op, rv;
   logic [23:0]   a_d;
   logic [7:0]    vec, rpre;
   logic [27:0]   rbits;
   bat_irq_en_s   ien;
   bat_nonaudio_s na;
   bat_status_s   st;
   int            mismatches, total_checks;
   bat_transmitter i_dut (.core_clk_in(clk), .srst_in(srst), .out_pin_dedicated_in(o_ded),
      .clk_pin_dedicated_in(c_ded), .clock_source_select_in(2'h0), .irq_enable_in(ien),
      .force_block_start_set_in(sb), .audio_wr_in(a_wr), .audio_data_in(a_d),
      .nonaudio_wr_in(n_wr), .nonaudio_bits_in(na), .underrun_clr_in(u_clr), .block_clr_in(1'b0),
      .force_block_start_out(sb_q), .status_out(st), .irq_req_out(irq), .irq_vector_out(vec),
      .output_pin_gpio_alias_in(g_val), .output_pin_gpio_oe_in(1'b0),
      .serial_audio_out_pin_out(pin), .serial_audio_out_pin_oe_out(oe),
      .external_audio_clock_pin_in(1'b0), .clock_pin_gpio_alias_out(c_free), .operating_out(op));
   bat_rx_model i_rx (.clk_in(clk), .arm_in(op), .line_in(pin), .valid_out(rv),
      .pre_out(rpre), .bits_out(rbits));
   initial forever #5 clk = ~clk;
   task automatic chk(string w, logic [27:0] x, logic [27:0] g);
      total_checks++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", w, x, g);
      end
   endtask
   // audio, then v u c, then even parity on top
   function automatic logic [27:0] sx(logic [23:0] d, bat_na_s n);
      return {^{n, d}, n, d};
   endfunction
   task automatic get_sub();
      @(negedge clk);
      for (int i = 0; i < 1100 && rv !== 1'b1; i++) @(negedge clk);
      chk("subframe", 1, rv);
   endtask
   task automatic t_gpio();
      g_val <= 1'b1;
      repeat (3) @(posedge clk);
      chk("gpio pin", 1, pin);
      chk("pin enable idle", 0, oe);
      c_ded <= 1'b1;
      g_val <= 1'b0;
      @(negedge clk);
      chk("clock pin free", 1, c_free);
      chk("pin enable", 1, oe);
      $display("gpio test done");
   endtask
   task automatic t_frame();
      ien <= 3'h1;
      o_ded <= 1'b1;
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
      chk("empty vector", 8'h2e, vec);
      @(posedge clk);
      n_wr <= 1'b1;
      na <= 6'h2b;
      @(posedge clk);
      {n_wr, a_wr, sb, a_d} <= {3'h3, 24'h5a3c01};
      @(posedge clk);
      a_d <= 24'h8000fe;
      @(posedge clk);
      {a_wr, sb} <= 2'h0;
      for (int i = 0; i < 6 && rbits !== sx(24'h5a3c01, na.chan_a); i++) get_sub();
      chk("chan a", sx(24'h5a3c01, na.chan_a), rbits);
      chk("z preamble", `BAT_PRE_Z, rpre);
      chk("start bit", 0, sb_q);
      get_sub();
      chk("y preamble", `BAT_PRE_Y, rpre);
      chk("chan b", sx(24'h8000fe, na.chan_b), rbits);
      ien <= 3'h7;
      get_sub();
      chk("x preamble", `BAT_PRE_X, rpre);
      chk("chan a again", sx(24'h5a3c01, na.chan_a), rbits);
      chk("underrun vector", 8'h28, vec);
      u_clr <= 1'b1;
      @(posedge clk);
      u_clr <= 1'b0;
      @(negedge clk);
      chk("underrun clear", 0, st.underrun_flag);
      $display("frame test done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      {srst, o_ded, c_ded, sb, a_wr, n_wr, u_clr, g_val} = 8'h80;
      {a_d, ien, na} = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_gpio();
      t_frame();
      summarize();
   end
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule // biphase_audio_transmitter_bench
`default_nettype wire
